// ===== design/fpd_cell_array.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_cell_array
	import fpd_pkg::*;
#(
	parameter int WORD_COUNT = WORDS,
	parameter int AW         = ADDR_W
) (
	input  wire logic          mclk,
	input  wire logic [AW-1:0] raddr,
	output logic               rdata,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic          wdata
);
	logic mem [WORD_COUNT];

	// No reset on storage: contents are undefined after power-up
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge mclk) begin
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ===== design/fpd_dram.sv
// Contract
// - Addresses change only in phase four
// - Phase one precharges common node
// - Phase two precharges output, senses cell
// - Phase three precharges common node again
// - Write stores input bit in phase four
// - Read shows bit after phase two, rewrites
// - Two 512-cell halves form 1024x1
// - Five row, five column lines decoded
// - Column decoder drives 64 amplifiers
// - Two selects plus bare-drain output
// - Read is non-destructive and refreshes
// - Each amplifier serves 16 cells
// - Phase three holds output, restores next
// - Access from phase four end, 270 ns
// - Refresh is automatic, no command; code only rewrites each accessed cell, at the next phase four end
`timescale 1ns/1ps
`default_nettype none
module fpd_dram
	import fpd_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             ph1_n,
	input  wire logic             ph2_n,
	input  wire logic             ph3_n,
	input  wire logic             ph4_n,
	input  wire logic [ROW_W-1:0] row_select_lines,
	input  wire logic [COL_W-1:0] column_select_lines,
	input  wire logic             unit_sel_a,
	input  wire logic             unit_sel_b,
	input  wire logic             read_not_write,
	input  wire logic             data_in,
	output logic                  data_out_o,
	output logic                  data_out_oe,
	output logic                  access_busy
);
	// Pin synchronisers: two flops before any logic looks at a pin
	localparam int PIN_W = 4 + ADDR_W + 4;
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			// Clocks are active low on the pins
			pin_meta <= {~ph1_n, ~ph2_n, ~ph3_n, ~ph4_n, row_select_lines, column_select_lines,
				unit_sel_a, unit_sel_b, read_not_write, data_in};
			pin_sync <= pin_meta;
		end
	end

	fpd_phases_s ph;
	fpd_addr_s   addr_pin;
	logic        sel_a;
	logic        sel_b;
	logic        rd_pin;
	logic        din_pin;

	assign ph       = pin_sync[PIN_W-1 -: 4];
	assign addr_pin = pin_sync[4 +: ADDR_W];
	assign sel_a    = pin_sync[3];
	assign sel_b    = pin_sync[2];
	assign rd_pin   = pin_sync[1];
	assign din_pin  = pin_sync[0];

	logic ph4_prev;
	logic ph2_prev;
	logic ph4_fall;
	logic ph2_fall;
	logic ph1_rise;
	logic ph1_prev;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ph4_prev <= 1'b0;
			ph2_prev <= 1'b0;
			ph1_prev <= 1'b0;
		end else begin
			ph4_prev <= ph.ph4;
			ph2_prev <= ph.ph2;
			ph1_prev <= ph.ph1;
		end
	end

	assign ph4_fall = ph4_prev & ~ph.ph4;
	assign ph2_fall = ph2_prev & ~ph.ph2;
	assign ph1_rise = ph.ph1 & ~ph1_prev;

	// Address, direction and selects are frozen at the close of phase four
	fpd_addr_s addr_q;
	logic      rd_q;
	logic      sel_q;
	logic      din_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= '0;
			rd_q   <= 1'b1;
			sel_q  <= 1'b0;
		end else if (ph4_fall) begin
			addr_q <= addr_pin;
			rd_q   <= rd_pin;
			sel_q  <= sel_a & sel_b;
		end
	end

	// Write data is sampled late, in phase three, ahead of the restore at the end of phase four
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			din_q <= RESET_DATA;
		end else if (ph.ph3) begin
			din_q <= din_pin;
		end
	end

	// Phase tracker; illegal orders simply hold the machine in place
	fpd_phase_e phase;
	fpd_phase_e next_phase;

	always_comb begin
		next_phase = phase;
		unique case (phase)
			FPD_IDLE:    if (ph1_rise) next_phase = FPD_PRE_ONE;
			FPD_PRE_ONE: if (ph.ph2) next_phase = FPD_SENSE;
			FPD_SENSE:   if (ph.ph3) next_phase = FPD_PRE_TWO;
			FPD_PRE_TWO: if (ph4_fall) next_phase = FPD_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= FPD_IDLE;
		end else begin
			phase <= next_phase;
		end
	end

	// Precharge markers, kept as observable state of the dynamic nodes
	logic node_precharged;
	logic out_precharged;
	logic amp_precharged;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			node_precharged <= 1'b0;
			out_precharged  <= 1'b0;
			amp_precharged  <= 1'b0;
		end else begin
			if (ph.ph1 || ph.ph3) begin
				node_precharged <= 1'b1;
			end else if (ph.ph2) begin
				node_precharged <= 1'b0;
			end
			if (ph.ph2) begin
				out_precharged <= 1'b1;
			end else if (ph2_fall) begin
				out_precharged <= 1'b0;
			end
			if (ph.ph3) begin
				amp_precharged <= 1'b1;
			end else if (ph4_fall) begin
				amp_precharged <= 1'b0;
			end
		end
	end

	// One of 32 columns times two halves selects one of the 64 amplifiers
	function automatic logic [5:0] amp_index(input fpd_addr_s a);
		amp_index = {a.row_select_lines[ROW_W-1], a.column_select_lines};
	endfunction

	// Amplifier first, then one of its 16 cells from the low row bits
	function automatic logic [ADDR_W-1:0] cell_index(input fpd_addr_s a);
		cell_index = {amp_index(a), a.row_select_lines[ROW_W-2:0]};
	endfunction

	logic sensed;
	logic amp_latch;
	logic restore_we;
	logic restore_bit;

	fpd_cell_array u_cells (
		.mclk  (mclk),
		.raddr (cell_index(addr_q)),
		.rdata (sensed),
		.we    (restore_we),
		.waddr (cell_index(addr_q)),
		.wdata (restore_bit)
	);

	// Amplifier latches the sensed bit at the end of phase two
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			amp_latch <= RESET_DATA;
		end else if (ph2_fall) begin
			amp_latch <= sensed;
		end
	end

	// Every completed cycle rewrites the cell, so any access refreshes the one addressed cell
	assign restore_bit = (sel_q && !rd_q) ? din_q : amp_latch;
	assign restore_we  = ph4_fall && (phase == FPD_PRE_TWO);

	// Output shows the read bit from end of phase two until the end of the next phase four
	logic out_bit;
	logic out_drive;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_bit   <= 1'b0;
			out_drive <= 1'b0;
		end else if (ph2_fall) begin
			out_bit   <= sensed;
			out_drive <= sel_q && rd_q && sensed;
		end else if (ph.ph2 || ph4_fall) begin
			out_drive <= 1'b0;
		end
	end

	// Bare drain: only a one is driven, a zero leaves the shared line to the pull-down
	assign data_out_o  = out_bit;
	assign data_out_oe = out_drive;
	assign access_busy = (phase != FPD_IDLE);

	// Rows are not tracked for age: refresh depends on the controller's cycling
	// Access time is the controller's phase four to phase two span plus three clocks

	sequence ph2_end_s;
		$fell(ph.ph2);
	endsequence

	sequence shows_read_s;
		##1 (data_out_o == $past(sensed));
	endsequence

	property read_shows_bit_p;
		@(posedge mclk) disable iff (!rst_n)
			ph2_end_s |-> shows_read_s;
	endproperty

	read_out_value_a: assert property (read_shows_bit_p)
		else $error("read bit not shown after phase two");

	unselected_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!sel_q |-> !data_out_oe)
		else $error("output driven while unselected");

	addr_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!ph4_fall |=> $stable(addr_q))
		else $error("address changed outside phase four end");

	restore_only_ph4_a: assert property (@(posedge mclk) disable iff (!rst_n)
		restore_we |-> ph4_fall)
		else $error("cell restore outside phase four end");

	write_data_used_a: assert property (@(posedge mclk) disable iff (!rst_n)
		restore_we && sel_q && !rd_q |-> restore_bit == din_q)
		else $error("write bit not stored");

	read_rewrite_a: assert property (@(posedge mclk) disable iff (!rst_n)
		restore_we && rd_q |-> restore_bit == amp_latch)
		else $error("read did not rewrite sensed bit");

	node_precharge_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ph.ph1 |=> node_precharged)
		else $error("common node not precharged in phase one");

	node_again_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ph.ph3 |=> node_precharged && amp_precharged)
		else $error("node or amplifier not precharged in phase three");

	out_precharge_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ph.ph2 |=> out_precharged)
		else $error("output not precharged in phase two");

	hold_in_ph3_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ph.ph3 && !ph2_fall |=> $stable(data_out_o))
		else $error("output changed during phase three");

	oe_needs_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		data_out_oe |-> sel_q && rd_q && data_out_o)
		else $error("output driven without a selected read of a one");

	oe_precharge_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ph.ph2 |=> !data_out_oe)
		else $error("output still driven in phase two");

	amp_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ph4_fall |=> !amp_precharged)
		else $error("amplifier precharge held past restore");

	din_frozen_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!ph.ph3 |=> $stable(din_q))
		else $error("write bit sampled outside phase three");

	busy_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ph1_rise && phase == FPD_IDLE |=> access_busy)
		else $error("cycle start not tracked");
endmodule
`default_nettype wire

// ===== pkg/fpd_pkg.sv
`default_nettype none
package fpd_pkg;
	localparam int ROW_W        = 5;
	localparam int COL_W        = 5;
	localparam int HALF_ROWS    = 16;
	localparam int HALF_COLS    = 32;
	localparam int HALF_WORDS   = 512;
	localparam int WORDS        = 1024;
	localparam int AMP_COUNT    = 64;
	localparam int CELLS_PER_AMP = 16;
	localparam int ADDR_W       = ROW_W + COL_W;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int ACCESS_NS    = 270;
	localparam int ACCESS_CYC   = (ACCESS_NS * 1000) / CLK_PERIOD_PS;
	localparam int REFRESH_US   = 2000;
	localparam int REFRESH_CYC  = (REFRESH_US * 1000000) / CLK_PERIOD_PS;
	localparam logic RESET_DATA = 1'b0;

	typedef enum logic [1:0] {
		FPD_IDLE    = 2'b00,
		FPD_PRE_ONE = 2'b01,
		FPD_SENSE   = 2'b11,
		FPD_PRE_TWO = 2'b10
	} fpd_phase_e;

	typedef struct packed {
		logic ph1;
		logic ph2;
		logic ph3;
		logic ph4;
	} fpd_phases_s;

	typedef struct packed {
		logic [ROW_W-1:0] row_select_lines;
		logic [COL_W-1:0] column_select_lines;
	} fpd_addr_s;
endpackage
`default_nettype wire

// ===== sim/four_phase_dynamic_ram_1k_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("ERROR %s exp %b got %b", nm, e, g); end end
module four_phase_dynamic_ram_1k_tb;
	import fpd_pkg::*;
	localparam logic [9:0] ADR [8] = '{10'h000, 10'h3ff, 10'h1ff, 10'h200, 10'h01f, 10'h3e0, 10'h2a5, 10'h15a};
	localparam logic [7:0] DAT     = 8'h59;
	logic        mclk  = 1'b0;
	logic        rst_n = 1'b0;
	logic        slow  = 1'b0;
	fpd_phases_s ph_n;
	fpd_addr_s   addr;
	logic [1:0]  sel;
	logic        rnw;
	logic        din;
	logic        dout;
	logic        doe;
	logic        busy;
	logic        line;
	logic        exp_mem [WORDS];
	int          err_total = 0;
	int          checked   = 0;
	int          cyc       = 0;

	always #2.5 mclk = ~mclk;
	// Bare drain pulls high; external pull-down holds a released line low
	assign line = doe ? dout : 1'b0;

	fpd_ctrl_model i_ctrl (.mclk(mclk), .slow(slow), .ph_n(ph_n), .addr(addr), .sel(sel), .rnw(rnw), .din(din));

	fpd_dram i_dut (
		.mclk(mclk), .rst_n(rst_n),
		.ph1_n(ph_n.ph1), .ph2_n(ph_n.ph2), .ph3_n(ph_n.ph3), .ph4_n(ph_n.ph4),
		.row_select_lines(addr.row_select_lines), .column_select_lines(addr.column_select_lines),
		.unit_sel_a(sel[1]), .unit_sel_b(sel[0]), .read_not_write(rnw), .data_in(din),
		.data_out_o(dout), .data_out_oe(doe), .access_busy(busy)
	);

	task automatic conclude();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic access(input logic [9:0] a, input logic r, input logic [1:0] s, input logic d);
		i_ctrl.cycle(a, r, s, d);
		if (!r && s == 2'h3)
			exp_mem[a] = d;
	endtask

	// Half boundary and corners; each word read twice, in two passes over all eight
	task automatic t_rw();
		for (int i = 0; i < 8; i++)
			access(ADR[i], 1'b0, 2'h3, DAT[i]);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 8; i++) begin
				access(ADR[i], 1'b1, 2'h3, 1'b0);
				`CHK("read", exp_mem[ADR[i]], line)
			end
		end
	endtask

	// Either select low: no drive; a write with only unit_sel_b low leaves the cell alone
	task automatic t_unsel();
		for (int s = 0; s < 3; s++) begin
			access(ADR[0], 1'b1, s[1:0], 1'b0);
			`CHK("unsel_oe", 1'b0, doe)
		end
		access(ADR[0], 1'b0, 2'h2, 1'b0);
		access(ADR[0], 1'b1, 2'h3, 1'b0);
		`CHK("busy", 1'b1, busy)
		`CHK("unsel_wr", exp_mem[ADR[0]], line)
	endtask

	task automatic t_slow();
		slow = 1'b1;
		access(ADR[3], 1'b0, 2'h3, ~DAT[3]);
		access(ADR[3], 1'b1, 2'h3, 1'b0);
		`CHK("slow_rd", ~DAT[3], line)
		slow = 1'b0;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		repeat (19) @(negedge mclk);
		`CHK("oe_rst", 1'b0, doe)
		`CHK("busy_rst", 1'b0, busy)
		@(negedge mclk);
		rst_n = 1'b1;
		repeat (2) @(negedge mclk);
		t_rw();
		t_unsel();
		t_slow();
		conclude();
	end
endmodule
`default_nettype wire

// ===== sim/fpd_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_ctrl_model
	import fpd_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       slow,
	output var fpd_phases_s ph_n,
	output var fpd_addr_s   addr,
	output var logic [1:0]  sel,
	output var logic        rnw,
	output var logic        din
);
	initial begin
		ph_n = 4'hf;
		addr = '0;
		sel  = 2'h0;
		rnw  = 1'b1;
		din  = 1'b0;
	end

	// Phases and gaps at least three clocks; slow mode doubles them
	task automatic hold_for();
		repeat (slow ? 6 : 3) @(negedge mclk);
	endtask

	// One access: phase four closes the prior cycle, then phases one to three
	// Whole run stays far inside the row sweep window
	task automatic cycle(input logic [9:0] a, input logic r, input logic [1:0] s, input logic d);
		for (int k = 0; k < 4; k++) begin
			@(negedge mclk);
			ph_n[k == 0 ? 0 : 4 - k] = 1'b0;
			if (k == 0) begin
				addr = a;
				rnw  = r;
				sel  = s;
				din  = d;
			end
			hold_for();
			ph_n = 4'hf;
			hold_for();
		end
	endtask
endmodule
`default_nettype wire
